/* design/codec_slot_pkg.sv */
/*
 * Constants, register map and state carriers for the codec serial slot
 * and buffer controller.
 * Assumes a 10 MHz system clock and a 32-bit APB master on that clock.
 */
package codec_slot_pkg;

	// Register byte offsets.
	localparam logic [7:0] OFS_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_FORMAT    = 8'h04;
	localparam logic [7:0] OFS_DIVIDER   = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0C;
	localparam logic [7:0] OFS_TX_SLOTS  = 8'h10;
	localparam logic [7:0] OFS_RX_SLOTS  = 8'h14;
	localparam logic [7:0] OFS_TX_BUF0   = 8'h20;
	localparam logic [7:0] OFS_RX_BUF0   = 8'h30;

	// Control register bit positions.
	localparam int BIT_ENABLE     = 15;
	localparam int BIT_LOOPBACK   = 11;
	localparam int BIT_CLK_DIR    = 10;
	localparam int BIT_SAMPLE_EDG = 9;
	localparam int BIT_FS_DIR     = 8;
	localparam int BIT_UNF_REPEAT = 7;
	localparam int BIT_IDLE_MODE  = 6;
	localparam int BIT_JUSTIFY    = 5;

	// Values after reset.
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] FORMAT_RESET  = 16'h0000;
	localparam logic [11:0] DIVIDER_RESET = 12'h000;
	localparam logic [15:0] SLOTS_RESET   = 16'h0000;

	typedef struct packed {
		logic        enable;
		logic        loopback_enable;
		logic        bit_clock_direction;
		logic        sample_edge_select;
		logic        frame_sync_direction;
		logic        underflow_repeat;
		logic        idle_slot_output_mode;
		logic        same_cycle_justify;
	} control_type;

	typedef struct packed {
		logic [1:0]  buffer_depth;
		logic [3:0]  words_per_frame;
		logic [3:0]  word_length_field;
	} format_type;

	// Pin bundle from the line side: bit clock, frame sync, serial in.
	typedef struct packed {
		logic        bclk;
		logic        fsync;
		logic        sdin;
	} pins_type;

endpackage

/* design/codec_slot_ctrl.sv */
/*
 * Codec serial slot, buffer and status controller with an APB register port.
 * Assumes a single 10 MHz clock; all pins are asynchronous to it and are
 * synchronised before use, so the bit clock must be well below clk_sys / 4.
 */
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module codec_slot_ctrl
	import codec_slot_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        bit_clock_pin_in,
	output logic             bit_clock_pin_out,
	output logic             bit_clock_pin_oe,
	input  wire logic        frame_sync_pin_in,
	output logic             frame_sync_pin_out,
	output logic             frame_sync_pin_oe,
	output logic             serial_out_pin_out,
	output logic             serial_out_pin_oe,
	input  wire logic        serial_in_pin
);

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		control_type       ctl;
		format_type        fmt;
		logic [11:0]       bit_clock_divider;
		logic [15:0]       tx_slot_enable;
		logic [15:0]       rx_slot_enable;
		pins_type          sync1;
		pins_type          sync2;
		logic              bclk_s3;
		logic [11:0]       gen_cnt;
		logic              bclk_gen;
		logic              running;
		logic [3:0]        bit_cnt;
		logic [3:0]        slot_cnt;
		logic [1:0]        ptr;
		logic [15:0]       tx_shift;
		logic [15:0]       rx_shift;
		logic              tx_active;
		logic [3:0][15:0]  transmit_buffer;
		logic [3:0][15:0]  tx_shadow;
		logic [3:0][15:0]  receive_buffer;
		logic [3:0][15:0]  rx_shadow;
		logic [3:0]        tx_written;
		logic [3:0]        rx_unread;
		logic [3:0]        unf_loc;
		logic [3:0]        ovf_loc;
		logic              tx_buffer_empty;
		logic              rx_buffer_full;
		logic              sdo;
		logic              sdo_oe;
		logic              fs_out;
		logic              clk_oe;
		logic              fs_oe;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} state_type;

	state_type st_q;
	state_type st_d;

	// Locations 0..depth are in use; the rest touch no flag but tx_buffer_empty, which a write to any location clears.
	function automatic logic [3:0] in_use(input logic [1:0] depth);
		logic [3:0] m;
		m = 4'h0;
		for (int i = 0; i < 4; i++) begin
			m[i] = (2'(i) <= depth);
		end
		return m;
	endfunction

	// Moves a word of len+1 bits up so its first bit sits at bit 15.
	function automatic logic [15:0] left_justify(input logic [15:0] w, input logic [3:0] len);
		return w << (4'hF - len);
	endfunction

	// A slot counts only when it lies inside the configured frame.
	function automatic logic slot_on(input logic [15:0] en, input logic [3:0] slot,
		input logic [3:0] words);
		return en[slot] && (slot <= words);
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic        bclk_rise;
	logic        bclk_fall;
	logic        sample_ev;
	logic        drive_ev;
	logic        fs_seen;
	logic        sdin_eff;
	logic        word_end;
	logic        frame_end;
	logic        start_now;
	logic        advance;
	logic        xfer;
	logic        gen_toggle;
	logic [15:0] rx_word;
	logic [3:0]  use_mask;
	logic        apb_done;
	logic        wr_en;
	logic        rd_en;
	logic [1:0]  widx;

	// Edge events and slot decisions from the registered state; bus strobes from the APB inputs.
	always_comb begin
		use_mask   = in_use(st_q.fmt.buffer_depth);
		gen_toggle = st_q.ctl.enable && !st_q.ctl.bit_clock_direction
			&& (st_q.bit_clock_divider != 12'h000)
			&& (st_q.gen_cnt == st_q.bit_clock_divider);
		if (st_q.ctl.bit_clock_direction) begin
			bclk_rise = st_q.sync2.bclk && !st_q.bclk_s3;
			bclk_fall = !st_q.sync2.bclk && st_q.bclk_s3;
		end else begin
			bclk_rise = gen_toggle && !st_q.bclk_gen;
			bclk_fall = gen_toggle && st_q.bclk_gen;
		end
		sample_ev = st_q.ctl.sample_edge_select ? bclk_rise : bclk_fall;
		drive_ev  = st_q.ctl.sample_edge_select ? bclk_fall : bclk_rise;
		fs_seen   = st_q.ctl.frame_sync_direction ? st_q.sync2.fsync : st_q.fs_out;
		sdin_eff  = st_q.ctl.loopback_enable ? st_q.sdo : st_q.sync2.sdin;
		word_end  = st_q.running && (st_q.bit_cnt == st_q.fmt.word_length_field);
		frame_end = word_end && (st_q.slot_cnt == st_q.fmt.words_per_frame);
		// Mid-frame syncs are ignored; a new frame needs the old one done.
		start_now = sample_ev && fs_seen && (!st_q.running || frame_end);
		rx_word   = left_justify({st_q.rx_shift[14:0], sdin_eff}, st_q.fmt.word_length_field);
		advance   = sample_ev && word_end
			&& (slot_on(st_q.tx_slot_enable, st_q.slot_cnt, st_q.fmt.words_per_frame)
			|| slot_on(st_q.rx_slot_enable, st_q.slot_cnt, st_q.fmt.words_per_frame));
		xfer      = advance && (st_q.ptr == st_q.fmt.buffer_depth);
		apb_done  = psel && penable && st_q.pready;
		wr_en     = apb_done && pwrite;
		rd_en     = apb_done && !pwrite;
		widx      = paddr[3:2];
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: pins, bit clock, framing, buffers, then the bus port.
	always_comb begin
		st_d = st_q;
		st_d.sync1   = '{bclk: bit_clock_pin_in, fsync: frame_sync_pin_in, sdin: serial_in_pin};
		st_d.sync2   = st_q.sync1;
		st_d.bclk_s3 = st_q.sync2.bclk;

		// Internal bit clock: half period of divider + 1 system cycles.
		if (gen_toggle) begin
			st_d.gen_cnt  = 12'h000;
			st_d.bclk_gen = !st_q.bclk_gen;
		end else if (st_q.ctl.enable && !st_q.ctl.bit_clock_direction
			&& st_q.bit_clock_divider != 12'h000) begin
			st_d.gen_cnt = st_q.gen_cnt + 12'h001;
		end

		// Master sync marks the period that precedes bit 0, or bit 0 itself.
		if (drive_ev) begin
			st_d.fs_out = st_q.ctl.same_cycle_justify ? !st_q.running
				: (!st_q.running || (st_q.bit_cnt == st_q.fmt.word_length_field
				&& st_q.slot_cnt == st_q.fmt.words_per_frame));
			st_d.sdo    = st_q.tx_active ? st_q.tx_shift[15] : 1'b0;
			st_d.sdo_oe = st_q.ctl.enable && (st_q.tx_active
				|| !st_q.ctl.idle_slot_output_mode);
		end

		// Driving low from enable on keeps the line from floating before the first edge.
		if (st_q.ctl.enable && !st_q.ctl.idle_slot_output_mode) begin
			st_d.sdo_oe = 1'b1;
		end

		// Sampling edge: shift, count bits and slots, store and advance.
		if (sample_ev && st_q.running) begin
			st_d.rx_shift = {st_q.rx_shift[14:0], sdin_eff};
			st_d.tx_shift = {st_q.tx_shift[14:0], 1'b0};
			st_d.bit_cnt  = st_q.bit_cnt + 4'h1;
			if (word_end) begin
				st_d.bit_cnt  = 4'h0;
				st_d.slot_cnt = st_q.slot_cnt + 4'h1;
				if (slot_on(st_q.rx_slot_enable, st_q.slot_cnt, st_q.fmt.words_per_frame)) begin
					st_d.rx_shadow[st_q.ptr] = rx_word;
				end
				if (advance) begin
					st_d.ptr = st_q.ptr + 2'h1;
				end
				if (frame_end) begin
					st_d.running  = 1'b0;
					st_d.slot_cnt = 4'h0;
				end
			end
		end

		// Buffer exchange with the shadows; flag sets follow bus clears below.
		if (xfer) begin
			st_d.ptr = 2'h0;
			for (int i = 0; i < 4; i++) begin
				if (use_mask[i]) begin
					st_d.tx_shadow[i] = (st_q.tx_written[i] || st_q.ctl.underflow_repeat)
						? st_q.transmit_buffer[i] : 16'h0000;
					st_d.unf_loc[i]   = !st_q.tx_written[i];
					st_d.receive_buffer[i] = (i == 32'(st_q.ptr))
						? st_d.rx_shadow[i] : st_q.rx_shadow[i];
					st_d.ovf_loc[i]   = st_q.ovf_loc[i] || st_q.rx_unread[i];
				end
			end
			st_d.tx_written = 4'h0;
		end

		// Frame start: slot 0 begins now (justified) or next bit clock.
		if (start_now) begin
			st_d.running  = 1'b1;
			st_d.slot_cnt = 4'h0;
			st_d.bit_cnt  = 4'h0;
			if (st_q.ctl.same_cycle_justify) begin
				st_d.bit_cnt  = 4'h1;
				st_d.rx_shift = {15'h0000, sdin_eff};
				st_d.tx_shift = {st_q.tx_shift[14:0], 1'b0};
			end
		end

		// Load the word for the slot about to be driven.
		if (start_now && !st_q.ctl.same_cycle_justify
			|| sample_ev && word_end && !frame_end) begin
			st_d.tx_active = slot_on(st_q.tx_slot_enable, st_d.slot_cnt,
				st_q.fmt.words_per_frame);
			st_d.tx_shift  = st_d.tx_shadow[st_d.ptr];
		end else if (!st_d.running) begin
			// Idle: preview slot 0 so a justified start has its first bit out.
			st_d.tx_active = st_q.ctl.same_cycle_justify && st_q.tx_slot_enable[0];
			st_d.tx_shift  = st_d.tx_shadow[st_d.ptr];
		end

		// Bus side effects and clears; hardware sets below take priority.
		st_d.pready  = psel && penable && !st_q.pready;
		st_d.pslverr = 1'b0;
		if (psel && penable && !st_q.pready) begin
			st_d.prdata  = 32'h0000_0000;
			if (paddr == OFS_CONTROL) begin
				st_d.prdata[15:0] = {st_q.ctl.enable, 3'h0, st_q.ctl.loopback_enable,
					st_q.ctl.bit_clock_direction, st_q.ctl.sample_edge_select,
					st_q.ctl.frame_sync_direction, st_q.ctl.underflow_repeat,
					st_q.ctl.idle_slot_output_mode, st_q.ctl.same_cycle_justify, 5'h00};
			end else if (paddr == OFS_FORMAT) begin
				st_d.prdata[15:0] = {4'h0, st_q.fmt.buffer_depth, 2'h0,
					st_q.fmt.words_per_frame, st_q.fmt.word_length_field};
			end else if (paddr == OFS_DIVIDER) begin
				st_d.prdata[11:0] = st_q.bit_clock_divider;
			end else if (paddr == OFS_STATUS) begin
				st_d.prdata[15:0] = {4'h0, st_q.slot_cnt, 4'h0,
					|(st_q.ovf_loc & use_mask), st_q.rx_buffer_full,
					|(st_q.unf_loc & use_mask), st_q.tx_buffer_empty};
			end else if (paddr == OFS_TX_SLOTS) begin
				st_d.prdata[15:0] = st_q.tx_slot_enable;
			end else if (paddr == OFS_RX_SLOTS) begin
				st_d.prdata[15:0] = st_q.rx_slot_enable;
			end else if (paddr[7:4] == OFS_TX_BUF0[7:4]) begin
				st_d.prdata[15:0] = st_q.transmit_buffer[widx];
			end else if (paddr[7:4] == OFS_RX_BUF0[7:4]) begin
				st_d.prdata[15:0] = st_q.receive_buffer[widx];
			end else begin
				st_d.pslverr = 1'b1;
			end
		end
		if (wr_en) begin
			if (paddr == OFS_CONTROL) begin
				st_d.ctl = '{enable: pwdata[BIT_ENABLE], loopback_enable: pwdata[BIT_LOOPBACK],
					bit_clock_direction: pwdata[BIT_CLK_DIR],
					sample_edge_select: pwdata[BIT_SAMPLE_EDG],
					frame_sync_direction: pwdata[BIT_FS_DIR],
					underflow_repeat: pwdata[BIT_UNF_REPEAT],
					idle_slot_output_mode: pwdata[BIT_IDLE_MODE],
					same_cycle_justify: pwdata[BIT_JUSTIFY]};
			end else if (paddr == OFS_FORMAT) begin
				st_d.fmt = '{buffer_depth: pwdata[11:10], words_per_frame: pwdata[7:4],
					word_length_field: pwdata[3:0]};
			end else if (paddr == OFS_DIVIDER) begin
				st_d.bit_clock_divider = pwdata[11:0];
			end else if (paddr == OFS_TX_SLOTS) begin
				st_d.tx_slot_enable = pwdata[15:0];
			end else if (paddr == OFS_RX_SLOTS) begin
				st_d.rx_slot_enable = pwdata[15:0];
			end else if (paddr[7:4] == OFS_TX_BUF0[7:4]) begin
				st_d.transmit_buffer[widx] = pwdata[15:0];
				st_d.tx_written[widx]      = 1'b1;
				st_d.unf_loc[widx]         = 1'b0;
				st_d.tx_buffer_empty       = 1'b0;
			end
		end
		if (rd_en && paddr[7:4] == OFS_RX_BUF0[7:4]) begin
			st_d.rx_unread[widx] = 1'b0;
			st_d.ovf_loc[widx] = 1'b0;
		end
		if (st_q.rx_buffer_full && !(|(st_d.rx_unread & use_mask))) begin
			st_d.rx_buffer_full = 1'b0;
		end

		// Transfer sets win over same-cycle clears.
		if (xfer) begin
			st_d.tx_buffer_empty = 1'b1;
			st_d.rx_buffer_full  = 1'b1;
			// Every in-use location now holds data that software has yet to read.
			st_d.rx_unread       = use_mask;
			for (int i = 0; i < 4; i++) begin
				if (use_mask[i] && !st_q.tx_written[i]) begin
					st_d.unf_loc[i] = 1'b1;
				end
				if (use_mask[i] && st_q.rx_unread[i]) begin
					st_d.ovf_loc[i] = 1'b1;
				end
			end
		end

		// A disabled block clears framing and flags; configuration, buffers and shadows are kept.
		if (!st_d.ctl.enable) begin
			st_d.running         = 1'b0;
			st_d.bit_cnt         = 4'h0;
			st_d.slot_cnt        = 4'h0;
			st_d.ptr             = 2'h0;
			st_d.tx_shift        = 16'h0000;
			st_d.rx_shift        = 16'h0000;
			st_d.tx_active       = 1'b0;
			st_d.unf_loc         = 4'h0;
			st_d.ovf_loc         = 4'h0;
			st_d.rx_unread       = 4'h0;
			st_d.tx_buffer_empty = 1'b0;
			st_d.rx_buffer_full  = 1'b0;
			st_d.gen_cnt         = 12'h000;
			st_d.bclk_gen        = 1'b0;
			st_d.fs_out          = 1'b0;
			st_d.sdo             = 1'b0;
			st_d.sdo_oe          = 1'b0;
		end

		// Pin enables leave a flip-flop like every other output.
		st_d.clk_oe = st_d.ctl.enable && !st_d.ctl.bit_clock_direction;
		st_d.fs_oe  = st_d.ctl.enable && !st_d.ctl.frame_sync_direction;
	end

	////////////////////////////////////////////////////////////////////////
	// State register with synchronous active-low reset.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			st_q                   <= '0;
			st_q.ctl               <= control_type'(CONTROL_RESET[15:8]);
			st_q.fmt               <= format_type'(FORMAT_RESET[9:0]);
			st_q.bit_clock_divider <= DIVIDER_RESET;
			st_q.tx_slot_enable    <= SLOTS_RESET;
			st_q.rx_slot_enable    <= SLOTS_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Every output is a field of the state register.
	assign prdata             = st_q.prdata;
	assign pready             = st_q.pready;
	assign pslverr            = st_q.pslverr;
	assign bit_clock_pin_out  = st_q.bclk_gen;
	assign bit_clock_pin_oe   = st_q.clk_oe;
	assign frame_sync_pin_out = st_q.fs_out;
	assign frame_sync_pin_oe  = st_q.fs_oe;
	assign serial_out_pin_out = st_q.sdo;
	assign serial_out_pin_oe  = st_q.sdo_oe;

endmodule

`default_nettype wire

/* bench/codec_slot_ctrl_chk.sv */
/*
 * Port checker for the codec slot controller, attached by bind.
 * Assumes an APB master that keeps the protocol and a stable divider while running.
 */
`timescale 1ns/1ps
`default_nettype none

module codec_slot_ctrl_chk
	import codec_slot_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        bit_clock_pin_in,
	input wire logic        bit_clock_pin_out,
	input wire logic        bit_clock_pin_oe,
	input wire logic        frame_sync_pin_in,
	input wire logic        frame_sync_pin_out,
	input wire logic        frame_sync_pin_oe,
	input wire logic        serial_out_pin_out,
	input wire logic        serial_out_pin_oe,
	input wire logic        serial_in_pin
);
	logic [15:0] ctl_q;
	logic [11:0] dv_q;
	logic [12:0] half_q;
	logic        seen_q;

	////////////////////////////////////////////////////////////////////////////
	// Shadows of control and divider, so pin rules can be tied to the setup.
	// The first half period after enable is counted from before the enable and reads long, hence the seen flag.
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ctl_q  <= 16'h0000;
			dv_q   <= 12'h000;
			half_q <= 13'h0000;
			seen_q <= 1'b0;
		end else begin
			if (psel && penable && pready && pwrite && paddr == OFS_CONTROL) ctl_q <= pwdata[15:0];
			if (psel && penable && pready && pwrite && paddr == OFS_DIVIDER) dv_q <= pwdata[11:0];
			half_q <= $changed(bit_clock_pin_out) ? 13'h0001 : half_q + 13'h0001;
			seen_q <= bit_clock_pin_oe && (seen_q || $changed(bit_clock_pin_out));
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence access_wait;
		psel && penable && !pready;
	endsequence

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake and pin drive rules.
	ready_after_wait_a: assert property (access_wait |=> pready)
		else $error("pready missing after the wait cycle");
	ready_one_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	error_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("pslverr without pready or with read data");
	released_quiet_a: assert property ($rose(rst_b) |-> !pready && !serial_out_pin_oe
		&& !bit_clock_pin_oe && !frame_sync_pin_oe)
		else $error("outputs active right after reset");
	idle_drive_a: assert property ((ctl_q[BIT_ENABLE] && !ctl_q[BIT_IDLE_MODE])[*4]
		|-> serial_out_pin_oe)
		else $error("serial out not driven in drive-low mode");
	disabled_quiet_a: assert property ((!ctl_q[BIT_ENABLE])[*4]
		|-> !serial_out_pin_oe && !bit_clock_pin_oe && !frame_sync_pin_oe)
		else $error("pins driven while disabled");
	sync_drive_a: assert property ((ctl_q[BIT_ENABLE] && !ctl_q[BIT_FS_DIR])[*4]
		|-> frame_sync_pin_oe)
		else $error("frame sync not driven as master");
	half_period_a: assert property (seen_q && bit_clock_pin_oe
		&& $changed(bit_clock_pin_out) |-> half_q == {1'b0, dv_q} + 13'h0001)
		else $error("bit clock half period wrong");
endmodule

bind codec_slot_ctrl codec_slot_ctrl_chk i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .bit_clock_pin_in(bit_clock_pin_in),
	.bit_clock_pin_out(bit_clock_pin_out), .bit_clock_pin_oe(bit_clock_pin_oe),
	.frame_sync_pin_in(frame_sync_pin_in), .frame_sync_pin_out(frame_sync_pin_out),
	.frame_sync_pin_oe(frame_sync_pin_oe), .serial_out_pin_out(serial_out_pin_out),
	.serial_out_pin_oe(serial_out_pin_oe), .serial_in_pin(serial_in_pin));

`default_nettype wire

/* bench/codec_partner.sv */
/*
 * Behavioural codec on the far side of the serial slot bus.
 * Assumes the controller is clock and sync master and samples on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module codec_partner #(
	parameter logic [7:0] PATTERN = 8'hA5
) (
	input  wire logic        bclk,
	input  wire logic        fsync,
	input  wire logic        sdo,
	input  wire logic        sdo_oe,
	output logic             sdi,
	output logic      [15:0] heard
);
	logic [2:0] bit_q;

	initial begin
		bit_q = 3'h0;
		sdi = 1'b0;
		heard = 16'h0000;
	end

	// A sync seen on this edge makes the next bit the first one of slot zero.
	// A released data line reads as the inverse of its last bit, never as a hold.
	always @(negedge bclk) begin
		bit_q <= fsync ? 3'h0 : bit_q + 3'h1;
		heard <= {heard[14:0], sdo_oe ? sdo : ~heard[0]};
	end

	// MSB first, so the same byte repeats across any slot length.
	always @(posedge bclk) begin
		sdi <= PATTERN[3'h7 - bit_q];
	end
endmodule

`default_nettype wire

/* bench/codec_serial_slot_buffer_control_tb_top.sv */
/*
 * Self-checking bench for the codec slot controller with a codec model.
 * Assumes the register map of the package and one wait state on APB.
 */
`timescale 1ns/1ps
`default_nettype none

module codec_serial_slot_buffer_control_tb_top;
	import codec_slot_pkg::*;

	logic        clk_sys;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        bclk_out;
	logic        bclk_oe;
	logic        fs_out;
	logic        fs_oe;
	logic        sdo_out;
	logic        sdo_oe;
	logic        sdi;
	logic        bclk_line;
	logic        fs_line;
	logic [15:0] heard;
	int          failures;
	int          checked;

	// Undriven pins rest low, so the clock stands still while the controller does not drive it.
	assign bclk_line = bclk_oe ? bclk_out : 1'b0;
	assign fs_line = fs_oe ? fs_out : 1'b0;

	codec_slot_ctrl i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bit_clock_pin_in(bclk_line), .bit_clock_pin_out(bclk_out),
		.bit_clock_pin_oe(bclk_oe), .frame_sync_pin_in(fs_line), .frame_sync_pin_out(fs_out),
		.frame_sync_pin_oe(fs_oe), .serial_out_pin_out(sdo_out), .serial_out_pin_oe(sdo_oe),
		.serial_in_pin(sdi));

	codec_partner i_codec (.bclk(bclk_line), .fsync(fs_line), .sdo(sdo_out), .sdo_oe(sdo_oe),
		.sdi(sdi), .heard(heard));

	////////////////////////////////////////////////////////////////////////////
	// Bus and comparison helpers.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Request is held until pready is sampled high or 16 cycles pass, then released.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, {16'h0000, d}, r, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0000_0000, r, e);
	endtask

	// Polls status until the given flag is set, bounded.
	task automatic poll(input int b, output logic [31:0] r);
		int n;
		n = 0;
		do begin
			rd(OFS_STATUS, r);
			n++;
		end while (r[b] !== 1'b1 && n < 600);
		if (r[b] !== 1'b1) failures++;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_reset_values;
		logic [31:0] r;
		logic        e;
		logic [7:0]  regs [6] = '{OFS_CONTROL, OFS_FORMAT, OFS_DIVIDER, OFS_STATUS,
			OFS_TX_SLOTS, OFS_RX_SLOTS};
		wr(OFS_STATUS, 16'h000F);
		foreach (regs[i]) begin
			rd(regs[i], r);
			check("reset value", r, 32'h0000_0000);
		end
		apb(1'b0, 8'hFC, 32'h0000_0000, r, e);
		check("unmapped error", {31'h0, e}, 32'h0000_0001);
		check("unmapped data", r, 32'h0000_0000);
	endtask

	// Two 8-bit slots, two-word buffers, codec data only; flags walk through a cycle.
	task automatic t_receive;
		logic [31:0] r;
		wr(OFS_FORMAT, 16'h0417);
		wr(OFS_DIVIDER, 16'h0003);
		wr(OFS_TX_SLOTS, 16'h0003);
		wr(OFS_RX_SLOTS, 16'h0003);
		wr(OFS_CONTROL, 16'h8000);
		poll(2, r);
		check("first status", r & 32'h0000_000F, 32'h0000_0007);
		check("silent output", {16'h0000, heard}, 32'h0000_0000);
		poll(3, r);
		check("overflow status", r & 32'h0000_000F, 32'h0000_000F);
		rd(OFS_RX_BUF0, r);
		check("rx word 0", r, 32'h0000_A500);
		rd(OFS_RX_BUF0 + 8'h04, r);
		check("rx word 1", r, 32'h0000_A500);
		rd(OFS_STATUS, r);
		check("rx flags cleared", r & 32'h0000_000F, 32'h0000_0003);
		wr(OFS_TX_BUF0, 16'h5A00);
		wr(OFS_TX_BUF0 + 8'h04, 16'h3C00);
		rd(OFS_STATUS, r);
		check("tx flags cleared", r & 32'h0000_000F, 32'h0000_0000);
	endtask

	// Loopback of 16-bit words with repeat on underflow; the codec's pattern is ignored.
	task automatic t_loopback;
		logic [31:0] r;
		wr(OFS_CONTROL, 16'h0000);
		rd(OFS_STATUS, r);
		check("status after disable", r, 32'h0000_0000);
		wr(OFS_FORMAT, 16'h041F);
		wr(OFS_TX_BUF0, 16'h1234);
		wr(OFS_TX_BUF0 + 8'h04, 16'hBEEF);
		wr(OFS_CONTROL, 16'h8880);
		poll(3, r);
		rd(OFS_RX_BUF0, r);
		rd(OFS_RX_BUF0 + 8'h04, r);
		poll(2, r);
		rd(OFS_RX_BUF0, r);
		check("loop word 0", r, 32'h0000_1234);
		rd(OFS_RX_BUF0 + 8'h04, r);
		check("loop word 1", r, 32'h0000_BEEF);
	endtask

	// Justified frames sampled on the rising edge with idle slots floating; the
	// shadows still repeat the last written words, so any bit slip shows in the data.
	task automatic t_justified;
		logic [31:0] r;
		wr(OFS_CONTROL, 16'h0000);
		wr(OFS_CONTROL, 16'h8AE0);
		poll(3, r);
		rd(OFS_RX_BUF0, r);
		check("justified word 0", r, 32'h0000_1234);
		rd(OFS_RX_BUF0 + 8'h04, r);
		check("justified word 1", r, 32'h0000_BEEF);
	endtask

	task automatic finish_test;
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Clock, reset, sequence and watchdog.
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin
		failures = 0;
		checked = 0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_reset_values();
		t_receive();
		t_loopback();
		t_justified();
		finish_test();
	end

	// The sequence needs some two thousand cycles; this leaves a wide margin.
	initial begin
		repeat (60000) @(posedge clk_sys);
		failures++;
		finish_test();
	end
endmodule

`default_nettype wire
